// ### core/eflf_level_flag.sv
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "eflf_defs.svh"
module eflf_level_flag (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire eflf_pkg::eflf_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // in endpoints: byte writes by the filler, packets sent on usb
  input wire logic [3:0] fillWrite,
  input wire logic [3:0] pktSent,
  // out endpoints: total bytes held in each fifo
  input wire eflf_pkg::eflf_count_t outTotalA,
  input wire eflf_pkg::eflf_count_t outTotalB,
  input wire eflf_pkg::eflf_count_t outTotalC,
  input wire eflf_pkg::eflf_count_t outTotalD,
  // flags and commits to the outside
  output logic [3:0] programmableLevelFlag,
  output logic [3:0] commitPulse,
  // interrupt
  output logic irq
);
  import eflf_pkg::*;

  // register map, as word indices on the bus:
  //   threshold high a..d at the even indices, low a..d right after each
  //   config, then auto-commit lengths a..d, level, status and mask
  // config word:
  //   bits 3..0 endpoint runs in the in direction, one bit per endpoint
  //   bits 7..4 auto-commit enable, one bit per endpoint
  //   bit 8 high speed, which sets the bulk buffer to 512 bytes
  // threshold high word:
  //   bit 7 flag direction, bit 6 packet scope select
  //   bits 5..3 committed packet field, or upper out threshold bits
  //   bits 1..0 upper byte threshold bits on the larger fifos
  //   bits that a small fifo cannot use read back as zero
  // status and mask words:
  //   bits 3..0 flag rising edge, bits 7..4 packet committed
  //   status bits stick until a read of the status word
  // unmapped indices read zero and ignore writes; no wait states

  // register storage
  logic [7:0] thrLow_q [4]; // low threshold bytes
  logic [7:0] thrHigh_q [4]; // high threshold bytes
  logic [9:0] autoLen_q [4]; // auto-commit lengths
  logic [8:0] config_q; // direction, auto enable, speed
  logic [7:0] status_q; // sticky events
  logic [7:0] mask_q; // interrupt mask
  logic [31:0] rdata_q; // read data held for data phase
  logic wrPend_q; // write waiting for its data phase
  logic [29:0] wrIdx_q; // word index of pending write
  logic [3:0] flag_q; // previous flags for edge events

  // address phase decode
  wire addrPhase = hsel && hready && htrans[1];
  wire [29:0] idx = haddr[31:2];
  wire rdAccept = addrPhase && !hwrite;
  wire wrAccept = addrPhase && hwrite;

  // per endpoint index constants
  wire [29:0] idxHigh [4];
  wire [29:0] idxLow [4];
  assign idxHigh[0] = 30'(`EFLF_IDX_THR_HIGH_A);
  assign idxHigh[1] = 30'(`EFLF_IDX_THR_HIGH_B);
  assign idxHigh[2] = 30'(`EFLF_IDX_THR_HIGH_C);
  assign idxHigh[3] = 30'(`EFLF_IDX_THR_HIGH_D);
  assign idxLow[0] = 30'(`EFLF_IDX_THR_LOW_A);
  assign idxLow[1] = 30'(`EFLF_IDX_THR_LOW_B);
  assign idxLow[2] = 30'(`EFLF_IDX_THR_LOW_C);
  assign idxLow[3] = 30'(`EFLF_IDX_THR_LOW_D);

  // addresses are compared as whole word indices, so a byte or halfword
  // address inside a register word maps to that word
  // own register hits, at address phase
  wire hitConfig = (idx == 30'(`EFLF_IDX_CONFIG));
  wire hitLevel = (idx == 30'(`EFLF_IDX_LEVEL));
  wire hitStatus = (idx == 30'(`EFLF_IDX_STATUS));
  wire hitMask = (idx == 30'(`EFLF_IDX_MASK));

  // write-side hits, at data phase
  wire wrConfig = wrPend_q && (wrIdx_q == 30'(`EFLF_IDX_CONFIG));
  wire wrMask = wrPend_q && (wrIdx_q == 30'(`EFLF_IDX_MASK));

  // auto-commit enable and the speed bit only change commit lengths;
  // they never move the threshold layout
  // configuration fields
  wire [3:0] epIsIn = config_q[`EFLF_CFG_IN_LSB +: 4];
  wire [3:0] autoEn = config_q[`EFLF_CFG_AUTO_LSB +: 4];
  wire highSpeed = config_q[`EFLF_CFG_HS];
  // bulk buffer size by speed
  wire [9:0] bufSize = highSpeed ? `EFLF_BUF_HS : `EFLF_BUF_FS;

  // per endpoint working signals
  logic [31:0] readEp [4];
  logic [3:0] readEpHit;
  logic [3:0] flagNow;
  logic [3:0] commitNow;
  eflf_count_t outTotal [4];
  assign outTotal[0] = outTotalA;
  assign outTotal[1] = outTotalB;
  assign outTotal[2] = outTotalC;
  assign outTotal[3] = outTotalD;

  // each endpoint builds three thresholds from the same two bytes:
  //   a byte threshold inside the filling packet
  //   a committed packet field for the packets-plus-bytes compare
  //   a total byte threshold for the out direction
  // the out threshold is not contiguous: on the larger fifos bit ten does not follow bit nine,
  // on the small ones bit nine does not follow bit eight, so software must split its count by hand
  // the packet compare puts packets above bytes; it only orders correctly
  // while the byte count stays below 1024, which the 512 byte buffer
  // guarantees
  // the direction bit is read straight from the register, so a change of
  // direction shows on the flag one clock after the write lands

  genvar e;
  generate
    for (e = 0; e < 4; e++) begin : gEp
      // endpoints a and c have the larger fifos
      localparam bit LARGE = (e == 0) || (e == 2);
      localparam bit FIRST = (e == 0);
      // writable bits of the high register
      localparam logic [7:0] HMASK = LARGE ? `EFLF_HIGH_MASK_LARGE : `EFLF_HIGH_MASK_SMALL;
      // auto-commit index of this endpoint
      localparam logic [29:0] IDX_AUTO = 30'(`EFLF_IDX_AUTO_LEN_A + e);

      wire [7:0] hi = thrHigh_q[e];
      wire [7:0] lo = thrLow_q[e];
      wire flagDirection = hi[`EFLF_HI_DIR];
      wire packetScopeSelect = hi[`EFLF_HI_SCOPE];
      wire thresholdBitEight = hi[`EFLF_HI_B0];
      wire thresholdBitNine = LARGE ? hi[`EFLF_HI_B1] : hi[`EFLF_HI_B3];
      wire thresholdBitTen = LARGE ? hi[`EFLF_HI_B3] : hi[`EFLF_HI_B4];

      // byte threshold within one packet
      logic [9:0] byteThr;
      // packet count field for in endpoints
      logic [2:0] committedPacketField;
      // total byte threshold for out endpoints
      eflf_count_t outThr;
      if (LARGE) begin : gLarge
        assign byteThr = {hi[`EFLF_HI_B1], hi[`EFLF_HI_B0], lo};
      end else begin : gSmall
        assign byteThr = {1'b0, thresholdBitEight, lo};
      end
      // first endpoint uses all three field bits, others two
      if (FIRST) begin : gPktA
        assign committedPacketField = hi[`EFLF_HI_B5:`EFLF_HI_B3];
      end else begin : gPktX
        assign committedPacketField = {1'b0, hi[`EFLF_HI_B4:`EFLF_HI_B3]};
      end
      // split upper bits: b1:b0 / b3 / b4 / b5 by fifo size
      if (FIRST) begin : gOutA
        assign outThr = {hi[`EFLF_HI_B5], hi[`EFLF_HI_B4], thresholdBitTen,
          thresholdBitNine, thresholdBitEight, lo};
      end else if (LARGE) begin : gOutC
        assign outThr = {1'b0, hi[`EFLF_HI_B4], thresholdBitTen, thresholdBitNine,
          thresholdBitEight, lo};
      end else begin : gOutS
        assign outThr = {2'b00, thresholdBitTen, thresholdBitNine,
          thresholdBitEight, lo};
      end

      // a zero programmed length would commit on every byte and an oversize one would
      // overrun the buffer, so both fall back to the full buffer size
      // commit length: programmed length, else full buffer
      wire [9:0 ] autoLen = (autoLen_q[e] == '0 || autoLen_q[e] > bufSize) ? bufSize
        : autoLen_q[e];
      wire [9:0] commitLen = autoEn[e] ? autoLen : bufSize;

      // filling-packet byte count and committed packets
      logic [9:0] fillingPacketByteCount;
      logic [2:0] committed_packet_field;
      eflf_in_pkt_counter #(
        .BW(10),
        .PW(3)
      ) uCount (
        .clock(clock),
        .rstn(rstn),
        .enable(epIsIn[e]),
        .byteWrite(fillWrite[e]),
        .pktSent(pktSent[e]),
        .commitLen(commitLen),
        .fillBytes(fillingPacketByteCount),
        .committed_packet_field(committed_packet_field),
        .commitPulse(commitNow[e])
      );

      // an out endpoint ignores the in counters, which are held at zero
      // while the endpoint is not configured in
      // monitored level and threshold by direction and scope
      eflf_count_t level;
      eflf_count_t thr;
      always_comb begin
        if (!epIsIn[e]) begin
          level = outTotal[e];
          thr = outThr;
        end else if (packetScopeSelect) begin
          level = {3'b000, fillingPacketByteCount};
          thr = {3'b000, byteThr};
        end else begin
          level = {committed_packet_field, fillingPacketByteCount};
          thr = {committedPacketField, byteThr};
        end
      end

      // comparator and registered flag
      eflf_ep_flag uFlag (
        .clock(clock),
        .rstn(rstn),
        .level(level),
        .threshold(thr),
        .flagDirection(flagDirection),
        .flag(flagNow[e])
      );

      // write strobes for this endpoint
      wire wrHigh = wrPend_q && (wrIdx_q == idxHigh[e]);
      wire wrLow = wrPend_q && (wrIdx_q == idxLow[e]);
      wire wrAuto = wrPend_q && (wrIdx_q == IDX_AUTO);

      // the high word is masked on write so that unused bits, except bit 5 on endpoint c, read as zero
      // and cannot leak into the thresholds of a small fifo
      // threshold and auto-commit registers
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          thrHigh_q[e] <= `EFLF_THR_HIGH_RST & HMASK;
          thrLow_q[e] <= `EFLF_THR_LOW_RST;
          autoLen_q[e] <= `EFLF_AUTO_LEN_RST;
        end else begin
          if (wrHigh) begin
            thrHigh_q[e] <= hwdata[7:0] & HMASK;
          end
          if (wrLow) begin
            thrLow_q[e] <= hwdata[7:0];
          end
          if (wrAuto) begin
            autoLen_q[e] <= hwdata[9:0];
          end
        end
      end

      // read mux for this endpoint
      assign readEpHit[e] = (idx == idxHigh[e]) || (idx == idxLow[e]) || (idx == IDX_AUTO);
      assign readEp[e] = (idx == idxHigh[e]) ? {24'h000000, hi}
        : (idx == idxLow[e]) ? {24'h000000, lo}
        : (idx == IDX_AUTO) ? {22'h000000, autoLen_q[e]}
        : 32'h00000000;
    end
  endgenerate

  // status hazard: a read and a new event in the same cycle must not lose
  // the event, so the clear only removes the bits that the read returned
  // and the set term is or-ed in after the clear
  // a flag that goes high right after reset counts as a rising edge,
  // since the flag history resets low
  // events: flag rising edge and packet commit
  wire [7:0] eventSet = {commitNow, flagNow & ~flag_q};
  // status read clears what it returned; a new event wins
  wire [7:0] statusClr = (rdAccept && hitStatus) ? status_q : 8'h00;
  wire [7:0] status_d = (status_q & ~statusClr) | eventSet;

  // read data selection for the address phase
  wire [31:0] readOwn = hitConfig ? {23'h000000, config_q}
    : hitLevel ? {28'h0000000, flagNow}
    : hitStatus ? {24'h000000, status_q}
    : hitMask ? {24'h000000, mask_q}
    : 32'h00000000;
  wire [31:0] rdata_d = (|readEpHit) ? (readEp[0] | readEp[1] | readEp[2] | readEp[3])
    : readOwn;

  // reads are decoded in the address phase and held in a register, so a
  // read that follows a write to the same word returns the old value
  // writes wait one cycle for their data and land at the end of the data
  // phase; hwdata is never looked at outside a pending write
  // bus pipeline: read data and pending write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
      wrPend_q <= 1'b0;
      wrIdx_q <= 30'h00000000;
    end else begin
      wrPend_q <= wrAccept;
      if (addrPhase) begin
        wrIdx_q <= idx;
      end
      if (rdAccept) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // config, mask, status and flag history
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      config_q <= 9'h000;
      mask_q <= 8'h00;
      status_q <= 8'h00;
      flag_q <= 4'h0;
    end else begin
      if (wrConfig) begin
        config_q <= hwdata[8:0];
      end
      if (wrMask) begin
        mask_q <= hwdata[7:0];
      end
      status_q <= status_d;
      flag_q <= flagNow;
    end
  end

  // the slave never stalls and never errors, so hreadyout and hresp are
  // constants; the flags come straight from the per-endpoint flops and
  // the interrupt from status and mask flops, so no output glitches
  // outputs: zero-wait okay slave, flags, commits, interrupt
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign programmableLevelFlag = flagNow;
  assign commitPulse = commitNow;
  assign irq = |(status_q & mask_q);

  // hsize is accepted but only whole words are used
  wire unusedSize = ^hsize;
endmodule : eflf_level_flag

// ### core/eflf_defs.svh
`ifndef EFLF_DEFS_SVH
`define EFLF_DEFS_SVH
// register indices; the byte address is four times the index
`define EFLF_IDX_THR_HIGH_A 16'hE630
`define EFLF_IDX_THR_LOW_A 16'hE631
`define EFLF_IDX_THR_HIGH_B 16'hE632
`define EFLF_IDX_THR_LOW_B 16'hE633
`define EFLF_IDX_THR_HIGH_C 16'hE634
`define EFLF_IDX_THR_LOW_C 16'hE635
`define EFLF_IDX_THR_HIGH_D 16'hE636
`define EFLF_IDX_THR_LOW_D 16'hE637
`define EFLF_IDX_CONFIG 16'hE700
`define EFLF_IDX_AUTO_LEN_A 16'hE701
`define EFLF_IDX_LEVEL 16'hE705
`define EFLF_IDX_STATUS 16'hE706
`define EFLF_IDX_MASK 16'hE707
// threshold high register fields
`define EFLF_HI_DIR 7
`define EFLF_HI_SCOPE 6
`define EFLF_HI_B5 5
`define EFLF_HI_B4 4
`define EFLF_HI_B3 3
`define EFLF_HI_B1 1
`define EFLF_HI_B0 0
// reset values and writable-bit masks
`define EFLF_THR_HIGH_RST 8'h88
`define EFLF_THR_LOW_RST 8'h00
`define EFLF_HIGH_MASK_LARGE 8'hFB
`define EFLF_HIGH_MASK_SMALL 8'hD9
`define EFLF_AUTO_LEN_RST 10'h200
// config register fields
`define EFLF_CFG_IN_LSB 0
`define EFLF_CFG_AUTO_LSB 4
`define EFLF_CFG_HS 8
// status and mask layout
`define EFLF_ST_COMMIT_LSB 4
// bulk packet buffer sizes
`define EFLF_BUF_HS 10'h200
`define EFLF_BUF_FS 10'h040
`endif

// ### core/eflf_pkg.sv
package eflf_pkg;
  // monitored counts and thresholds, wide enough for 4096 bytes
  typedef logic [12:0] eflf_count_t;
  // ahb transfer types
  typedef enum logic [1:0] {
    EFLF_IDLE = 2'b00,
    EFLF_BUSY = 2'b01,
    EFLF_NONSEQ = 2'b10,
    EFLF_SEQ = 2'b11
  } eflf_htrans_t;
endpackage : eflf_pkg

// ### core/eflf_ep_flag.sv
`timescale 1ns/1ps
// one endpoint's level decision, registered every clock
module eflf_ep_flag (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // monitored level and programmed threshold
  input wire eflf_pkg::eflf_count_t level,
  input wire eflf_pkg::eflf_count_t threshold,
  input wire logic flagDirection,
  // registered flag
  output logic flag
);
  import eflf_pkg::*;
  // comparisons both ways
  wire atOrAbove = (level >= threshold);
  wire atOrBelow = (level <= threshold);
  wire flag_d = flagDirection ? atOrAbove : atOrBelow;
  // re-evaluated on every edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else begin
      flag <= flag_d;
    end
  end
endmodule : eflf_ep_flag

// ### core/eflf_in_pkt_counter.sv
`timescale 1ns/1ps
`include "eflf_defs.svh"
// filling-packet byte count, commit, and committed-packet count
module eflf_in_pkt_counter #(
  parameter int BW = 10,
  parameter int PW = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // events from filler and usb side
  input wire logic enable,
  input wire logic byteWrite,
  input wire logic pktSent,
  input wire logic [BW-1:0] commitLen,
  // counts and commit pulse
  output logic [BW-1:0] fillBytes,
  output logic [PW-1:0] committed_packet_field,
  output logic commitPulse
);
  import eflf_pkg::*;
  // commit once the next byte reaches the length
  wire [BW-1:0] fillNext = fillBytes + BW'(1);
  wire commitNow = enable && byteWrite && (fillNext >= commitLen);
  wire pktFull = &committed_packet_field;
  wire pktUp = commitNow && !pktFull;
  wire pktDown = pktSent && (committed_packet_field != '0);
  // byte and packet counters
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fillBytes <= '0;
      committed_packet_field <= '0;
      commitPulse <= 1'b0;
    end else begin
      commitPulse <= commitNow;
      if (!enable) begin
        fillBytes <= '0;
      end else if (commitNow) begin
        fillBytes <= '0;
      end else if (byteWrite) begin
        fillBytes <= fillNext;
      end
      if (!enable) begin
        committed_packet_field <= '0;
      end else if (pktUp && !pktDown) begin
        committed_packet_field <= committed_packet_field + PW'(1);
      end else if (pktDown && !pktUp) begin
        committed_packet_field <= committed_packet_field - PW'(1);
      end
    end
  end
endmodule : eflf_in_pkt_counter

// ### verif/eflf_filler_model.sv
`timescale 1ns/1ps
// filler beside the in fifos: one byte a cycle, gaps when slow
module eflf_filler_model (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // request from the bench
  input wire logic go,
  input wire logic [1:0] ep,
  input wire logic [9:0] count,
  input wire logic slow,
  // towards the block
  output logic busy,
  output logic [3:0] fillWrite
);
  logic [9:0] left_q; // bytes still to write
  assign busy = (left_q != 10'h000);
  // byte pulses, never two in one cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_q <= 10'h000;
      fillWrite <= 4'h0;
    end else if (go) begin
      left_q <= count;
      fillWrite <= 4'h0;
    end else if (busy && !(slow && $urandom_range(1) == 0)) begin
      left_q <= left_q - 10'h001;
      fillWrite <= 4'h1 << ep;
    end else begin
      fillWrite <= 4'h0;
    end
  end
endmodule : eflf_filler_model

// ### verif/eflf_level_flag_monitor.sv
`timescale 1ns/1ps
// port watcher for the level flag block
module eflf_level_flag_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus
  input wire logic hsel,
  input wire eflf_pkg::eflf_htrans_t htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // endpoint side
  input wire logic [3:0] fillWrite,
  input wire logic [3:0] pktSent,
  input wire eflf_pkg::eflf_count_t outTotalA,
  input wire eflf_pkg::eflf_count_t outTotalB,
  input wire eflf_pkg::eflf_count_t outTotalC,
  input wire eflf_pkg::eflf_count_t outTotalD,
  input wire logic [3:0] programmableLevelFlag,
  input wire logic [3:0] commitPulse,
  input wire logic irq
);
  import eflf_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic acc; // transfer accepted
  logic actNow; // anything that may move a flag
  logic irqNow; // anything that may raise irq
  logic [51:0] totQ;
  logic [3:0] flagQ;
  logic [2:0] actQ;
  logic [3:0] irqQ;
  logic [3:0] busQ;
  assign acc = hsel & hready & htrans[1];
  assign actNow = acc | (|fillWrite) | (|pktSent)
    | (totQ != {outTotalA, outTotalB, outTotalC, outTotalD});
  assign irqNow = acc | (|commitPulse) | (|(programmableLevelFlag & ~flagQ));
  // cause history; reset fills it so release transients are excused
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      actQ <= 3'h7;
      irqQ <= 4'hF;
      busQ <= 4'hF;
      totQ <= '0;
      flagQ <= 4'h0;
    end else begin
      actQ <= {actQ[1:0], actNow};
      irqQ <= {irqQ[2:0], irqNow};
      busQ <= {busQ[2:0], acc};
      totQ <= {outTotalA, outTotalB, outTotalC, outTotalD};
      flagQ <= programmableLevelFlag;
    end
  end
  sequence s_noread;
    !(acc && !hwrite);
  endsequence
  sequence s_commit;
    commitPulse != 4'h0;
  endsequence
  bus_ready_a: assert property (hreadyout)
    else $error("hreadyout low");
  bus_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  rdata_hold_a: assert property (s_noread |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  rdata_width_a: assert property (hrdata[31:10] == 22'h0)
    else $error("hrdata upper bits set");
  commit_cause_a: assert property (
    s_commit |-> (commitPulse & ~$past(fillWrite)) == 4'h0)
    else $error("commit without a byte");
  flag_cause_a: assert property (
    $changed(programmableLevelFlag) |-> actQ != 3'h0)
    else $error("flag moved without cause");
  irq_rise_a: assert property ($rose(irq) |-> irqQ != 4'h0)
    else $error("irq rose without event");
  irq_fall_a: assert property ($fell(irq) |-> busQ != 4'h0)
    else $error("irq fell without access");
endmodule : eflf_level_flag_monitor
bind eflf_level_flag eflf_level_flag_monitor u_mon (.clock, .rstn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .fillWrite, .pktSent, .outTotalA,
  .outTotalB, .outTotalC, .outTotalD, .programmableLevelFlag, .commitPulse, .irq);

// ### verif/eflf_level_flag_tb.sv
`timescale 1ns/1ps
`include "eflf_defs.svh"
module eflf_level_flag_tb;
  import eflf_pkg::*;
  logic clock, rstn, hsel, hwrite, hready, hreadyout, hresp, irq, go, slow, busy;
  eflf_htrans_t htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [3:0] fillWrite, pktSent, flag, commit;
  logic [1:0] ep;
  logic [9:0] cnt;
  logic [7:0] h, l, v;
  logic [15:0] li;
  eflf_count_t t;
  eflf_count_t outTot [4];
  int errors = 0, n_compared = 0, commits = 0, k, len, c;
  assign hready = hreadyout; // single slave drives bus ready
  eflf_level_flag u_dut (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .fillWrite, .pktSent,
    .outTotalA(outTot[0]), .outTotalB(outTot[1]), .outTotalC(outTot[2]),
    .outTotalD(outTot[3]), .programmableLevelFlag(flag), .commitPulse(commit), .irq);
  eflf_filler_model u_fill (.clock, .rstn, .go, .ep, .count(cnt), .slow, .busy, .fillWrite);
  // 125 MHz clock
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  // count committed packets
  always @(posedge clock) commits <= commits + $countones(commit);
  task automatic test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // bounded wait for bus ready
  task automatic wrdy;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (hready !== 1'h1) begin
      errors++;
      test_done;
    end
  endtask : wrdy
  // one single-word transfer, read data left in q
  task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {14'h0, i, 2'h0};
    htrans <= EFLF_NONSEQ;
    hwrite <= w;
    wrdy;
    hsel <= 1'h0;
    htrans <= EFLF_IDLE;
    hwdata <= d;
    wrdy;
    q = hrdata;
  endtask : bus
  // n bytes into endpoint e, then let counts and flags land
  task automatic fill(input int e, input int n);
    go <= 1'h1;
    ep <= e[1:0];
    cnt <= n[9:0];
    slow <= 1'($urandom_range(1));
    @(posedge clock);
    go <= 1'h0;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (busy && k < 3000);
    if (busy) begin
      errors++;
      test_done;
    end
    repeat (4) @(posedge clock);
  endtask : fill
  function automatic logic [7:0] hmask(input int e);
    return e[0] ? `EFLF_HIGH_MASK_SMALL : `EFLF_HIGH_MASK_LARGE;
  endfunction : hmask
  // out threshold from its split bits
  function automatic eflf_count_t thr(input int e, input logic [7:0] a, input logic [7:0] b);
    case (e)
      0: return {a[5], a[4], a[3], a[1], a[0], b};
      2: return {1'h0, a[4], a[3], a[1], a[0], b};
      default: return {2'h0, a[4], a[3], a[0], b};
    endcase
  endfunction : thr
  function automatic logic want(input eflf_count_t lv, input eflf_count_t th, input logic d);
    return d ? (lv >= th) : (lv <= th);
  endfunction : want
  initial begin
    rstn = 1'h0;
    {hsel, hwrite, go, slow} = 4'h0;
    {haddr, hwdata, pktSent, ep, cnt} = '0;
    htrans = EFLF_IDLE;
    outTot = '{default: '0};
    void'($urandom(87));
    repeat (5) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    // reset values, read-write and writable masks
    for (int e = 0; e < 4; e++) begin
      li = 16'(`EFLF_IDX_THR_LOW_A + 2 * e);
      v = 8'($urandom);
      bus(0, li, 0);
      chk("low reset", `EFLF_THR_LOW_RST, q);
      bus(0, li - 16'h1, 0);
      chk("high reset", 32'(`EFLF_THR_HIGH_RST & hmask(e)), q);
      bus(1, li, v);
      bus(0, li, 0);
      chk("low rw", v, q);
      bus(1, li - 16'h1, 32'hFF);
      bus(0, li - 16'h1, 0);
      chk("high mask", hmask(e), q);
    end
    bus(0, 16'h1234, 0);
    chk("unmapped", 0, q);
    // out endpoints around the threshold, random direction
    for (int e = 0; e < 4; e++) for (int r = 0; r < 3; r++) begin
      li = 16'(`EFLF_IDX_THR_LOW_A + 2 * e);
      {h, l} = 16'($urandom);
      t = thr(e, h, l);
      bus(1, li - 16'h1, h);
      bus(1, li, l);
      for (int d = -1; d < 2; d++) begin
        outTot[e] <= eflf_count_t'(t + d);
        repeat (2) @(posedge clock);
        c = int'(want(eflf_count_t'(t + d), t, h[7]));
        chk("out flag", c, flag[e]);
      end
    end
    // in endpoints, auto-commit on the first at high speed
    len = $urandom_range(40, 3);
    bus(1, `EFLF_IDX_CONFIG, 32'h11F);
    bus(0, `EFLF_IDX_CONFIG, 0);
    chk("config rw", 32'h11F, q);
    bus(1, `EFLF_IDX_AUTO_LEN_A, len);
    bus(0, `EFLF_IDX_AUTO_LEN_A, 0);
    chk("auto len rw", len, q);
    bus(1, `EFLF_IDX_THR_HIGH_A, 32'hC0);
    bus(1, `EFLF_IDX_THR_LOW_A, len - 1);
    fill(0, len - 2);
    chk("below bytes", 0, flag[0]);
    fill(0, 1);
    chk("at bytes", 1, flag[0]);
    fill(0, 1);
    chk("auto commit", 1, commits);
    chk("bytes cleared", 0, flag[0]);
    // packets plus bytes, then bytes only
    bus(1, `EFLF_IDX_THR_HIGH_A, 32'h88);
    bus(1, `EFLF_IDX_THR_LOW_A, 2);
    fill(0, 2);
    chk("committed_packet_field plus bytes", 1, flag[0]);
    pktSent <= 4'h1;
    @(posedge clock);
    pktSent <= 4'h0;
    repeat (3) @(posedge clock);
    chk("pkt sent", 0, flag[0]);
    bus(1, `EFLF_IDX_THR_HIGH_A, 32'hC8);
    repeat (2) @(posedge clock);
    chk("bytes only", 1, flag[0]);
    bus(0, `EFLF_IDX_LEVEL, 0);
    chk("level reg", 1, q[0]);
    // buffer size bounds the packet: 512 high speed, 64 full speed
    for (int i = 0; i < 2; i++) begin
      bus(1, `EFLF_IDX_CONFIG, i ? 32'h01F : 32'h11F);
      c = commits;
      fill(i + 1, i ? 63 : 511);
      chk("no early commit", c, commits);
      fill(i + 1, 1);
      chk("buffer commit", c + 1, commits);
    end
    // commit interrupt unmasked, then masked
    for (int m = 1; m >= 0; m--) begin
      bus(1, `EFLF_IDX_MASK, m ? 32'hF0 : 32'h0);
      bus(0, `EFLF_IDX_STATUS, 0);
      fill(0, len);
      chk("irq", m, irq);
      bus(0, `EFLF_IDX_STATUS, 0);
      chk("status commit", 1, q[4]);
      repeat (2) @(posedge clock);
      chk("irq cleared", 0, irq);
    end
    test_done;
  end
endmodule : eflf_level_flag_tb
